//--- uart_status_flag_logic_test.sv
`timescale 1ns/1ns
`default_nettype none
module uart_status_flag_logic_test;
    import ufl_pkg::*;
    logic        mclk;
    logic        rst_b;
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        rx_line;
    logic        tx_line;
    logic        irq;
    logic        listen;
    int          num_errors;
    int          compares;
    int          cycles;
    ufl_status_flags #(.BAUD_DEFAULT(16'h0000)) u_dut (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .serial_receive_pin(rx_line), .serial_transmit_pin(tx_line), .irq(irq));
    ufl_far_end u_far (.mclk(mclk), .serial_receive_pin(rx_line), .serial_transmit_pin(tx_line), .listen(listen));
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_get(input logic [2:0] a, output logic [15:0] v);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_get
    task automatic rd_chk(input logic [2:0] a, input logic [15:0] e);
        logic [15:0] v;
        rd_get(a, v);
        chk(v, e);
    endtask : rd_chk
    task automatic rx_char(input logic [7:0] d, input logic stop);
        u_far.send(d, stop);
        repeat (4) @(posedge mclk);
    endtask : rx_char
    task automatic wait_idle();
        logic [15:0] v;
        v = 16'hFFFF;
        for (int i = 0; i < 600 && v !== 16'h0000; i++) rd_get(ADDR_STATUS, v);
        chk(v, 16'h0000);
    endtask : wait_idle
    task automatic end_of_test();
        $display("num_errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    initial begin
        mclk = 1'b0;
        rst_b = 1'b0;
        addr = 3'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        listen = 1'b1;
        num_errors = 0;
        compares = 0;
        cycles = 0;
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        rd_chk(ADDR_STATUS, 16'h0000);
        rd_chk(ADDR_INT_MASK, 16'h0000);
        rd_chk(ADDR_TX_BUF, 16'h0000);
        rd_chk(3'h7, 16'h0000);
        rx_char(8'hA5, 1'b1);
        rd_chk(ADDR_STATUS, 16'h0001);
        rd_chk(ADDR_INT_STAT, 16'h0001);
        rd_chk(ADDR_RX_BUF, 16'h00A5);
        rd_chk(ADDR_STATUS, 16'h0000);
        wr_reg(ADDR_INT_MASK, 16'h0001);
        #1 chk({15'h0, irq}, 16'h0001);
        wr_reg(ADDR_INT_STAT, 16'h0001);
        #1 chk({15'h0, irq}, 16'h0000);
        rd_chk(ADDR_STATUS, 16'h0000);
        rx_char(8'h3C, 1'b1);
        rd_chk(ADDR_RX_BUF, 16'h003C);
        rd_chk(ADDR_STATUS, 16'h0001);
        rx_char(8'h55, 1'b1);
        rd_chk(ADDR_STATUS, 16'h0005);
        rd_chk(ADDR_RX_BUF, 16'h003C);
        rd_chk(ADDR_STATUS, 16'h0000);
        rx_char(8'h81, 1'b0);
        rd_chk(ADDR_STATUS, 16'h0003);
        rd_chk(ADDR_RX_BUF, 16'h0081);
        rd_chk(ADDR_STATUS, 16'h0000);
        rx_char(8'h81, 1'b1);
        rd_chk(ADDR_STATUS, 16'h0001);
        rx_char(8'h42, 1'b1);
        rd_chk(ADDR_RX_BUF, 16'h0081);
        rd_chk(ADDR_STATUS, 16'h0004);
        rd_chk(ADDR_RX_BUF, 16'h0081);
        rd_chk(ADDR_STATUS, 16'h0000);
        wr_reg(ADDR_INT_STAT, 16'h0003);
        wr_reg(ADDR_INT_MASK, 16'h0002);
        wr_reg(ADDR_TX_BUF, 16'h005A);
        rd_chk(ADDR_STATUS, 16'h0010);
        chk({15'h0, irq}, 16'h0001);
        wr_reg(ADDR_TX_BUF, 16'h00C3);
        rd_chk(ADDR_STATUS, 16'h0018);
        wait_idle();
        rd_chk(ADDR_INT_STAT, 16'h0002);
        chk({8'h00, u_far.got[0]}, 16'h005A);
        chk({8'h00, u_far.got[1]}, 16'h00C3);
        listen <= 1'b0;
        wr_reg(ADDR_CTRL, 16'h0001);
        wr_reg(ADDR_TX_BUF, 16'h0000);
        wait_idle();
        wr_reg(ADDR_CTRL, 16'h0000);
        chk(16'(u_far.n), 16'h0002);
        end_of_test();
    end
endmodule : uart_status_flag_logic_test
`default_nettype wire

//--- ufl_baud_div.sv
`timescale 1ns/1ns
`default_nettype none
module ufl_baud_div
    import ufl_pkg::*;
#(
    parameter int DIV_W = 16
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_b,
    // divisor and oversample tick
    input  wire logic [DIV_W-1:0] divisor,
    output logic                  tick
);

    logic [DIV_W-1:0] count;
    wire              wrap = (count >= divisor);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
            tick  <= 1'b0;
        end else begin
            count <= wrap ? '0 : count + 1'b1;
            tick  <= wrap;
        end
    end

endmodule : ufl_baud_div
`default_nettype wire

//--- ufl_far_end.sv
`timescale 1ns/1ns
`default_nettype none
module ufl_far_end
    import ufl_pkg::*;
(
    // clock
    input  wire logic mclk,
    // serial pins
    output logic      serial_receive_pin,
    input  wire logic serial_transmit_pin,
    // receiver enable
    input  wire logic listen
);
    logic [7:0] got [0:3];
    logic [7:0] b;
    int         n;
    initial begin
        serial_receive_pin = 1'b1;
        n = 0;
    end
    // start, eight bits lsb first, stop; line idles high after
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        @(posedge mclk);
        for (int i = 0; i < FRAME_BITS; i++) begin
            serial_receive_pin <= f[i];
            repeat (OVERSAMPLE) @(posedge mclk);
        end
        serial_receive_pin <= 1'b1;
    endtask : send
    // capture characters from the transmit pin, sampled mid bit
    always begin
        @(negedge serial_transmit_pin iff listen);
        repeat (8) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge mclk);
            b[i] = serial_transmit_pin;
        end
        repeat (16) @(posedge mclk);
        got[n[1:0]] = b;
        n++;
    end
endmodule : ufl_far_end
`default_nettype wire

//--- ufl_pkg.sv
package ufl_pkg;

    // register indices on the plain port
    localparam logic [2:0] ADDR_STATUS   = 3'h0;
    localparam logic [2:0] ADDR_RX_BUF   = 3'h1;
    localparam logic [2:0] ADDR_TX_BUF   = 3'h2;
    localparam logic [2:0] ADDR_CTRL     = 3'h3;
    localparam logic [2:0] ADDR_BAUD     = 3'h4;
    localparam logic [2:0] ADDR_INT_STAT = 3'h5;
    localparam logic [2:0] ADDR_INT_MASK = 3'h6;

    // async_status_register fields
    localparam int ST_RX_FULL   = 0;
    localparam int ST_FRAME_ERR = 1;
    localparam int ST_OVERRUN   = 2;
    localparam int ST_TX_FULL   = 3;
    localparam int ST_TX_BUSY   = 4;

    // control, interrupt fields
    localparam int CTRL_IRDA = 0;
    localparam int INT_RX    = 0;
    localparam int INT_TX    = 1;

    // reset values
    localparam logic [15:0] BAUD_RESET = 16'h0043;
    localparam logic [1:0]  MASK_RESET = 2'h0;

    // bit timing in oversample ticks
    localparam int OVERSAMPLE    = 16;
    localparam int IR_PULSE_NUM  = 3;
    localparam int IR_PULSE_TKS  = IR_PULSE_NUM * OVERSAMPLE / 16;
    localparam int MID_TICK      = OVERSAMPLE / 2 - 1;
    localparam int FRAME_BITS    = 10;

    typedef struct packed {
        logic [7:0] data;
        logic       stop_ok;
    } ufl_rx_frame_s;

    typedef struct packed {
        logic [2:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } ufl_bus_req_s;

endpackage : ufl_pkg

//--- ufl_status_flags.sv
// What this block does
// - Loading a received character into the buffer sets rx_buffer_full_flag.
// - Buffer read after a status read showing the flag set clears it.
// - Flag set after the status read survives the buffer read.
// - Transmit done with empty holding buffer clears tx_busy_flag.
// - Restart from a written buffer sets tx_busy_flag and requests tx interrupt.
// - Move into shift register clears tx_buffer_full_flag unless the buffer is written in the same cycle, requests tx interrupt.
// - Any write to the transmit buffer sets tx_buffer_full_flag.
// - Flag 0 with overrun 1 means characters lost; both 0 means nothing received.
// - Infrared transmit pulse lasts three sixteenths of one bit period.
// - Character arriving before the old is read sets overrun, is discarded.
// - Zero sampled at the stop bit of a character loaded into the buffer sets framing error, requests rx interrupt.
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module ufl_status_flags
    import ufl_pkg::*;
#(
    parameter logic [15:0] BAUD_DEFAULT = BAUD_RESET
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // register port
    input  wire logic [2:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    // serial pins
    input  wire logic        serial_receive_pin,
    output logic             serial_transmit_pin,
    // interrupt
    output logic             irq
);

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } ufl_rx_e;

    function automatic logic hit(input logic [2:0] a, input logic [2:0] target);
        hit = (a == target);
    endfunction : hit

    ufl_bus_req_s req;
    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // register decode
    wire rd_status = req.rd && hit(req.addr, ADDR_STATUS);
    wire rd_rxbuf  = req.rd && hit(req.addr, ADDR_RX_BUF);
    wire wr_txbuf  = req.wr && hit(req.addr, ADDR_TX_BUF);
    wire wr_ctrl   = req.wr && hit(req.addr, ADDR_CTRL);
    wire wr_baud   = req.wr && hit(req.addr, ADDR_BAUD);
    wire wr_istat  = req.wr && hit(req.addr, ADDR_INT_STAT);
    wire wr_imask  = req.wr && hit(req.addr, ADDR_INT_MASK);

    // control state
    logic        irda_en;
    logic [15:0] baud_div;
    logic [1:0]  int_stat;
    logic [1:0]  int_mask;

    // flags
    logic       rx_buffer_full_flag;
    logic       ferr_flag;
    logic       overrun_flag;
    logic       tx_buffer_full_flag;
    logic       tx_busy_flag;
    logic [2:0] armed;
    logic [7:0] receive_holding_buffer;
    logic [7:0] transmit_holding_buffer;

    // oversample tick
    logic tick;

    ufl_baud_div #(
        .DIV_W (16)
    ) u_baud (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .divisor (baud_div),
        .tick    (tick)
    );

    // receiver
    ufl_rx_e       rx_st;
    logic [3:0]    rx_tks;
    logic [2:0]    rx_bits;
    logic [7:0]    rx_shift;
    ufl_rx_frame_s rx_frame;
    logic          rx_done;

    wire rx_mid  = tick && (rx_tks == 4'(MID_TICK));
    wire rx_full = tick && (rx_tks == 4'(OVERSAMPLE - 1));

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rx_st    <= RX_IDLE;
            rx_tks   <= '0;
            rx_bits  <= '0;
            rx_shift <= '0;
            rx_frame <= '0;
            rx_done  <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (tick) begin
                rx_tks <= rx_tks + 4'h1;
            end
            case (rx_st)
                RX_IDLE: begin
                    rx_tks <= '0;
                    if (tick && !serial_receive_pin) begin
                        rx_st <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_mid) begin
                        rx_tks  <= '0;
                        rx_bits <= '0;
                        rx_st   <= serial_receive_pin ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_full) begin
                        rx_shift <= {serial_receive_pin, rx_shift[7:1]};
                        rx_bits  <= rx_bits + 3'h1;
                        if (rx_bits == 3'h7) begin
                            rx_st <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_full) begin
                        rx_frame <= '{data: rx_shift, stop_ok: serial_receive_pin};
                        rx_done  <= 1'b1;
                        rx_st    <= RX_IDLE;
                    end
                end
                default: begin
                    rx_st <= RX_IDLE;
                end
            endcase
        end
    end

    // receive events
    wire rx_overrun = rx_done && rx_buffer_full_flag;
    wire rx_load    = rx_done && !rx_buffer_full_flag;
    wire rx_event   = rx_load || (rx_overrun && !overrun_flag);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            receive_holding_buffer <= '0;
        end else if (rx_load) begin
            receive_holding_buffer <= rx_frame.data;
        end
    end

    // arm on status read, disarm after buffer read
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            armed <= '0;
        end else if (rd_rxbuf) begin
            armed <= '0;
        end else if (rd_status) begin
            armed <= {overrun_flag, ferr_flag, rx_buffer_full_flag};
        end
    end

    wire clr_rx_buffer_full_flag = rd_rxbuf && armed[0];
    wire clr_ferr = rd_rxbuf && armed[1];
    wire clr_overrun_flag = rd_rxbuf && armed[2];

    // receive flags, a set beats a clear in the same cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rx_buffer_full_flag <= 1'b0;
            ferr_flag           <= 1'b0;
            overrun_flag        <= 1'b0;
        end else begin
            if (rx_load) begin
                rx_buffer_full_flag <= 1'b1;
            end else if (clr_rx_buffer_full_flag) begin
                rx_buffer_full_flag <= 1'b0;
            end
            if (rx_load && !rx_frame.stop_ok) begin
                ferr_flag <= 1'b1;
            end else if (clr_ferr) begin
                ferr_flag <= 1'b0;
            end
            if (rx_overrun) begin
                overrun_flag <= 1'b1;
            end else if (clr_overrun_flag) begin
                overrun_flag <= 1'b0;
            end
        end
    end

    // transmitter
    logic tx_busy_sh;
    logic tx_done;
    wire  tx_load = tx_buffer_full_flag && !tx_busy_sh && !tx_done;

    ufl_tx_shift u_tx (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .tick    (tick),
        .irda_en (irda_en),
        .load    (tx_load),
        .data    (transmit_holding_buffer),
        .busy    (tx_busy_sh),
        .done    (tx_done),
        .tx_pin  (serial_transmit_pin)
    );

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            transmit_holding_buffer <= '0;
        end else if (wr_txbuf) begin
            transmit_holding_buffer <= req.wdata[7:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tx_buffer_full_flag <= 1'b0;
            tx_busy_flag        <= 1'b0;
        end else begin
            if (wr_txbuf) begin
                tx_buffer_full_flag <= 1'b1;
            end else if (tx_load) begin
                tx_buffer_full_flag <= 1'b0;
            end
            if (tx_load) begin
                tx_busy_flag <= 1'b1;
            end else if (tx_done && !tx_buffer_full_flag) begin
                tx_busy_flag <= 1'b0;
            end
        end
    end

    // control registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irda_en  <= 1'b0;
            baud_div <= BAUD_DEFAULT;
            int_mask <= MASK_RESET;
        end else begin
            if (wr_ctrl) begin
                irda_en <= req.wdata[CTRL_IRDA];
            end
            if (wr_baud) begin
                baud_div <= req.wdata;
            end
            if (wr_imask) begin
                int_mask <= req.wdata[1:0];
            end
        end
    end

    // sticky interrupt status, write one to clear, set wins
    wire [1:0] int_set = {tx_load, rx_event};
    wire [1:0] int_clr = wr_istat ? req.wdata[1:0] : 2'h0;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            int_stat <= '0;
        end else begin
            int_stat <= int_set | (int_stat & ~int_clr);
        end
    end

    assign irq = |(int_stat & int_mask);

    // read data
    wire [15:0] status_word = {11'h000, tx_busy_flag, tx_buffer_full_flag,
                               overrun_flag, ferr_flag, rx_buffer_full_flag};
    logic [15:0] next_rdata;

    always_comb begin
        next_rdata = 16'h0000;
        if (hit(req.addr, ADDR_STATUS)) begin
            next_rdata = status_word;
        end else if (hit(req.addr, ADDR_RX_BUF)) begin
            next_rdata = {8'h00, receive_holding_buffer};
        end else if (hit(req.addr, ADDR_CTRL)) begin
            next_rdata = {15'h0000, irda_en};
        end else if (hit(req.addr, ADDR_BAUD)) begin
            next_rdata = baud_div;
        end else if (hit(req.addr, ADDR_INT_STAT)) begin
            next_rdata = {14'h0000, int_stat};
        end else if (hit(req.addr, ADDR_INT_MASK)) begin
            next_rdata = {14'h0000, int_mask};
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= req.rd ? next_rdata : 16'h0000;
        end
    end

endmodule : ufl_status_flags
`default_nettype wire

//--- ufl_status_flags_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module ufl_status_flags_checker
    import ufl_pkg::*;
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_b,
    // register port
    input wire logic [2:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    // pins and interrupt
    input wire logic        serial_receive_pin,
    input wire logic        serial_transmit_pin,
    input wire logic        irq
);
    logic irda;
    logic mask_tx;
    wire  ctrl_wr = wr && addr == ADDR_CTRL;
    wire  mask_wr = wr && addr == ADDR_INT_MASK;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) irda <= 1'b0;
        else if (ctrl_wr) irda <= wdata[CTRL_IRDA];
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) mask_tx <= 1'b0;
        else if (mask_wr) mask_tx <= wdata[INT_TX];
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    AST_RDATA_IDLE: assert property (!rd |=> rdata == 16'h0000)
        else $error("read data not zero outside a read");
    AST_REFUSED_READ: assert property (rd && (addr == ADDR_TX_BUF || addr == 3'h7) |=> rdata == 16'h0000)
        else $error("refused read not zero");
    AST_STATUS_UPPER: assert property (rd && addr == ADDR_STATUS |=> rdata[15:5] == 11'h000)
        else $error("status upper bits set");
    AST_RX_UPPER: assert property (rd && addr == ADDR_RX_BUF |=> rdata[15:8] == 8'h00)
        else $error("receive data upper bits set");
    AST_MASK_OFF: assert property (mask_wr && wdata[1:0] == 2'h0 |=> !irq)
        else $error("interrupt high with all masked");
    AST_TX_IRQ: assert property (wr && addr == ADDR_TX_BUF && mask_tx |-> ##[1:400] irq)
        else $error("no transmit interrupt");
    AST_IR_PULSE: assert property (irda && $rose(serial_transmit_pin)
        |-> serial_transmit_pin[*3] ##1 !serial_transmit_pin[*8] ##5 !serial_transmit_pin)
        else $error("infrared pulse width wrong");
    AST_BIT_LEN: assert property (!irda && $fell(serial_transmit_pin)
        |-> !serial_transmit_pin[*8] ##8 !serial_transmit_pin)
        else $error("transmit bit too short");
    cover property (rd && addr == ADDR_RX_BUF);
    cover property (irda && $rose(serial_transmit_pin));
    cover property ($rose(irq));
endmodule : ufl_status_flags_checker
bind ufl_status_flags ufl_status_flags_checker u_chk (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .serial_receive_pin(serial_receive_pin),
    .serial_transmit_pin(serial_transmit_pin), .irq(irq));
`default_nettype wire

//--- ufl_tx_shift.sv
`timescale 1ns/1ns
`default_nettype none
module ufl_tx_shift
    import ufl_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // timing and mode
    input  wire logic       tick,
    input  wire logic       irda_en,
    // character in
    input  wire logic       load,
    input  wire logic [7:0] data,
    // status and pin
    output logic            busy,
    output logic            done,
    output logic            tx_pin
);

    logic [FRAME_BITS-1:0] frame;
    logic [3:0]            tks;
    logic [3:0]            bits;
    logic                  line;

    wire last_tk = tick && (tks == 4'(OVERSAMPLE - 1));
    wire last_bt = (bits == 4'(FRAME_BITS - 1));
    wire ir_on   = (tks < 4'(IR_PULSE_TKS));

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            frame <= '1;
            tks   <= '0;
            bits  <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (load && !busy) begin
                frame <= {1'b1, data, 1'b0};
                tks   <= '0;
                bits  <= '0;
                busy  <= 1'b1;
            end else if (busy && tick) begin
                tks <= tks + 4'h1;
                if (last_tk) begin
                    frame <= {1'b1, frame[FRAME_BITS-1:1]};
                    bits  <= bits + 4'h1;
                    busy  <= !last_bt;
                    done  <= last_bt;
                end
            end
        end
    end

    assign line = busy ? frame[0] : 1'b1;

    // infrared: a short high pulse for each zero bit
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tx_pin <= 1'b1;
        end else if (irda_en) begin
            tx_pin <= busy && !frame[0] && ir_on;
        end else begin
            tx_pin <= line;
        end
    end

endmodule : ufl_tx_shift
`default_nettype wire
